// ==== tb/gpio_interrupt_bank_tb.sv ====
// Purpose: Self-checking bench for the pin interrupt bank
// Assumes: Ready sampled at the falling edge, inputs driven at the rising
// Notes: Response ready lines held high throughout
`timescale 1ns/1ns
module gpio_interrupt_bank_tb;
  typedef struct packed {
    logic [11:0] wa;
    logic [31:0] wd;
    logic [11:0] ra;
    logic [31:0] rv;
    logic irq;
  } row_t;
  logic clk = 1'b0, rst_b = 1'b0, clk_en = 1'b1, irq, awr, wr_rdy, arr, bv, rv;
  logic aw = 1'b0, w = 1'b0, ar = 1'b0;
  logic [31:0] lo = '0, hi = '0, wd = '0, rdata, rd;
  logic [11:0] awa = '0, ara = '0;
  logic [1:0] br, rr, resp;
  logic [7:0] rises;
  int num_errors = 0, cmp_count = 0, cycles = 0;
  row_t rows [11];
  gpio_interrupt_bank u_gpio_interrupt_bank (.clk_i(clk), .rst_b_i(rst_b), .clk_en_i(clk_en),
    .pin_event_low_i(lo), .pin_event_high_i(hi), .s_axi_awaddr_i(awa), .s_axi_awvalid_i(aw),
    .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(w),
    .s_axi_wready_o(wr_rdy), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(1'b1),
    .s_axi_araddr_i(ara), .s_axi_arvalid_i(ar), .s_axi_arready_o(arr), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(1'b1), .irq_o(irq));
  irq_sink_model u_irq_sink_model (.clk_i(clk), .rst_b_i(rst_b), .irq_i(irq), .rise_count_o(rises));
  initial
  begin
    forever #4 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // ****************************************
  // Bus cycles
  // ****************************************
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic ta;
    logic tw;
    logic tb;
    @(posedge clk);
    awa <= a;
    wd <= d;
    aw <= 1'b1;
    w <= 1'b1;
    tb = 1'b0;
    while (!tb)
    begin
      @(negedge clk);
      ta = aw && awr;
      tw = w && wr_rdy;
      tb = bv;
      resp = br;
      @(posedge clk);
      if (ta)
        aw <= 1'b0;
      if (tw)
        w <= 1'b0;
    end
  endtask
  task automatic rd_reg(input logic [11:0] a);
    logic ta;
    logic tr;
    @(posedge clk);
    ara <= a;
    ar <= 1'b1;
    tr = 1'b0;
    while (!tr)
    begin
      @(negedge clk);
      ta = ar && arr;
      tr = rv;
      rd = rdata;
      resp = rr;
      @(posedge clk);
      if (ta)
        ar <= 1'b0;
    end
  endtask
  task automatic pulse(input logic [31:0] l, input logic [31:0] h);
    @(posedge clk);
    lo <= l;
    hi <= h;
    @(posedge clk);
    lo <= '0;
    hi <= '0;
  endtask
  task automatic test_done();
    $display("Comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Bounded run; a hang counts as a mismatch
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      num_errors++;
      test_done();
    end
  end
  initial
  begin
    rows[0] = '{12'h200, 32'hFFFF_FFFF, 12'h200, 32'hFFFF_FFFF, 1'b0};
    rows[1] = '{12'h210, 32'hFFFF_FFFF, 12'h210, 32'h0003_FFFF, 1'b0};
    rows[2] = '{12'h20C, 32'h8000_0001, 12'h204, 32'h8000_0001, 1'b1};
    rows[3] = '{12'h208, 32'h0000_0001, 12'h204, 32'h8000_0000, 1'b1};
    rows[4] = '{12'h200, 32'h0000_0001, 12'h204, 32'h8000_0000, 1'b0};
    rows[5] = '{12'h208, 32'h8000_0000, 12'h204, 32'h0000_0000, 1'b0};
    rows[6] = '{12'h21C, 32'hFFFF_FFFF, 12'h214, 32'h0003_FFFF, 1'b1};
    rows[7] = '{12'h218, 32'hFFFF_FFFF, 12'h214, 32'h0000_0000, 1'b0};
    rows[8] = '{12'h204, 32'hFFFF_FFFF, 12'h204, 32'h0000_0000, 1'b0};
    rows[9] = '{12'h20C, 32'h0000_0001, 12'h20C, 32'h0000_0000, 1'b1};
    rows[10] = '{12'h208, 32'h0000_0001, 12'h204, 32'h0000_0000, 1'b0};
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      rd_reg(12'h200 + 12'(4 * i));
      chk("reset value", rd, 32'h0000_0000);
    end
    $display("Test reset values ended");
    for (int i = 0; i < 11; i++)
    begin
      wr(rows[i].wa, rows[i].wd);
      chk("write resp", {30'h0, resp}, {30'h0, pin_irq_pkg::RESP_OKAY});
      rd_reg(rows[i].ra);
      chk("read resp", {30'h0, resp}, {30'h0, pin_irq_pkg::RESP_OKAY});
      chk("row read", rd, rows[i].rv);
      chk("row irq", {31'h0, irq}, {31'h0, rows[i].irq});
    end
    $display("Test register rows ended");
    // Bit 18 of the high event word has no pin behind it
    pulse(32'h8000_0020, 32'h0006_0000);
    rd_reg(12'h214);
    chk("event high", rd, 32'h0002_0000);
    chk("event irq", {31'h0, irq}, 32'h1);
    rd_reg(12'h204);
    chk("event low", rd, 32'h8000_0020);
    wr(12'h218, 32'h0002_0000);
    wr(12'h208, 32'h0000_0020);
    // Pin event lands on the edge that applies a clear of the same bit
    fork
      wr(12'h208, 32'h8000_0000);
      begin
        @(posedge clk iff (aw && awr));
        lo <= 32'h8000_0000;
        @(posedge clk);
        lo <= '0;
      end
    join
    rd_reg(12'h204);
    chk("set beats clear", rd, 32'h8000_0000);
    wr(12'h208, 32'h8000_0000);
    chk("sink rises", {24'h0, rises}, 32'h4);
    @(posedge clk);
    clk_en <= 1'b0;
    pulse(32'h0000_0001, '0);
    @(posedge clk);
    clk_en <= 1'b1;
    rd_reg(12'h204);
    chk("frozen event", rd, 32'h0000_0000);
    $display("Test pin events ended");
    wr(12'h300, 32'hFFFF_FFFF);
    chk("unmapped write", {30'h0, resp}, {30'h0, pin_irq_pkg::RESP_SLVERR});
    rd_reg(12'h300);
    chk("unmapped read", {30'h0, resp}, {30'h0, pin_irq_pkg::RESP_SLVERR});
    wr(12'h20C, 32'h0000_0001);
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rd_reg(12'h204);
    chk("status after reset", rd, 32'h0000_0000);
    chk("irq after reset", {31'h0, irq}, 32'h0);
    $display("Test unmapped and second reset ended");
    test_done();
  end
endmodule

// ==== tb/irq_sink_model.sv ====
// Purpose: Stand-in for the processor interrupt controller
// Assumes: Level request on the same clock
// Notes: Counts request rises so lost or extra requests show
`timescale 1ns/1ns
module irq_sink_model
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic irq_i,
  output logic [7:0] rise_count_o
);
  logic irq_r;
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      irq_r <= 1'b0;
      rise_count_o <= 8'h00;
    end
    else
    begin
      irq_r <= irq_i;
      if (irq_i && !irq_r)
        rise_count_o <= rise_count_o + 8'h01;
    end
  end
endmodule

// ==== verilog/gpio_interrupt_bank.sv ====
// What this block does
// RULE1 - Enabled pins only forward pending interrupts
// RULE2 - Readable per-pin status register per bank
// RULE3 - Write one to clear drops status bit
// RULE4 - Write one to force raises status bit
// RULE5 - Low bank bit n is pin n
// RULE6 - High bank bits 0-17 are pins 32-49
// RULE7 - High bank bits 31:18 read zero, unwritable
// RULE8 - Enables and status zero after reset
// RULE9 - Request high while enabled status set
// RULE10 - Zeros ignored; set beats clear
//
// Purpose: Per-pin interrupt status, enable and request for 50 pins
// Assumes: Pin events are one-cycle pulses from same-clock detect logic
// Notes: Clear and force registers read as zero
`timescale 1ns/1ns
module gpio_interrupt_bank
#(
  parameter int LOW_PINS = pin_irq_pkg::LOW_PINS,
  parameter int HIGH_PINS = pin_irq_pkg::HIGH_PINS
)
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic clk_en_i,
  input wire logic [31:0] pin_event_low_i,
  input wire logic [31:0] pin_event_high_i,
  input wire logic [11:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [11:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic irq_o
);

  // Elaboration check: the low bank is a full word, the high bank fits one
  if (LOW_PINS != 32 || HIGH_PINS < 1 || HIGH_PINS > 32)
  begin
    $error("Unsupported pin counts");
  end

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] strb_mask(input logic [3:0] strb);
    strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

  localparam logic [31:0] HMASK = 32'((64'h1 << HIGH_PINS) - 64'h1);

  // ****************************************
  // Write channel capture
  // ****************************************
  logic [11:0] aw_addr_r;
  logic aw_held_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic w_held_r;
  logic wr_go;
  logic [31:0] wr_bits;
  logic wr_hit;

  // Either channel may arrive first; each is held until the response goes
  assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid_o;
  assign wr_bits = w_data_r & strb_mask(w_strb_r);
  assign wr_hit = (aw_addr_r[11:5] == pin_irq_pkg::OFF_ENABLE_LOW[11:5]);

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 12'h000;
      s_axi_awready_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
      if (s_axi_awvalid_i && s_axi_awready_o)
      begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr_i;
      end
      else if (wr_go)
      begin
        aw_held_r <= 1'b0;
      end
      s_axi_awready_o <= !aw_held_r && !(s_axi_awvalid_i && s_axi_awready_o);
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      w_held_r <= 1'b0;
      w_data_r <= pin_irq_pkg::REG_RESET;
      w_strb_r <= 4'h0;
      s_axi_wready_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
      if (s_axi_wvalid_i && s_axi_wready_o)
      begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata_i;
        w_strb_r <= s_axi_wstrb_i;
      end
      else if (wr_go)
      begin
        w_held_r <= 1'b0;
      end
      s_axi_wready_o <= !w_held_r && !(s_axi_wvalid_i && s_axi_wready_o);
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= pin_irq_pkg::RESP_OKAY;
    end
    else if (clk_en_i)
    begin
      if (wr_go)
      begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= wr_hit ? pin_irq_pkg::RESP_OKAY : pin_irq_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready_i)
      begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  // ****************************************
  // Enable and status banks
  // ****************************************
  pin_irq_pkg::bank_pair_t enable_r;
  pin_irq_pkg::bank_pair_t enable_nxt;
  pin_irq_pkg::bank_pair_t status_r;
  pin_irq_pkg::bank_pair_t status_nxt;
  pin_irq_pkg::bank_pair_t set_v;
  pin_irq_pkg::bank_pair_t clr_v;

  function automatic logic [31:0] sel(input logic [11:0] a, input logic [11:0] off, input logic [31:0] b);
    sel = (wr_go && a == off) ? b : 32'h0000_0000;
  endfunction

  always_comb
  begin
    // RULE5 RULE6 bit n maps to pin n / pin 32+n
    set_v.low = pin_event_low_i | sel(aw_addr_r, pin_irq_pkg::OFF_FORCE_LOW, wr_bits);
    set_v.high = (pin_event_high_i | sel(aw_addr_r, pin_irq_pkg::OFF_FORCE_HIGH, wr_bits)) & HMASK;
    // RULE3 write one clears
    clr_v.low = sel(aw_addr_r, pin_irq_pkg::OFF_CLEAR_LOW, wr_bits);
    clr_v.high = sel(aw_addr_r, pin_irq_pkg::OFF_CLEAR_HIGH, wr_bits);
    // RULE4 RULE10 set wins, zeros do nothing
    status_nxt.low = (status_r.low & ~clr_v.low) | set_v.low;
    status_nxt.high = ((status_r.high & ~clr_v.high) | set_v.high) & HMASK;
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      // RULE8 all clear after reset
      status_r <= {pin_irq_pkg::REG_RESET, pin_irq_pkg::REG_RESET};
    end
    else if (clk_en_i)
    begin
      status_r <= status_nxt;
    end
  end

  // Next enable is shared with the request so a disable takes effect at once
  always_comb
  begin
    enable_nxt = enable_r;
    if (wr_go && aw_addr_r == pin_irq_pkg::OFF_ENABLE_LOW)
    begin
      enable_nxt.low = (enable_r.low & ~strb_mask(w_strb_r)) | wr_bits;
    end
    // RULE7 reserved high bits never stored
    if (wr_go && aw_addr_r == pin_irq_pkg::OFF_ENABLE_HIGH)
    begin
      enable_nxt.high = ((enable_r.high & ~strb_mask(w_strb_r)) | wr_bits) & HMASK;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      enable_r <= {pin_irq_pkg::REG_RESET, pin_irq_pkg::REG_RESET};
    end
    else if (clk_en_i)
    begin
      enable_r <= enable_nxt;
    end
  end

  // ****************************************
  // Interrupt request
  // ****************************************
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      irq_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
      // RULE1 RULE9 registered so the output is a flop
      irq_o <= |(status_nxt.low & enable_nxt.low) || |(status_nxt.high & enable_nxt.high);
    end
  end

  // ****************************************
  // Read channel
  // ****************************************
  pin_irq_pkg::read_answer_t rd_v;

  always_comb
  begin
    rd_v.resp = pin_irq_pkg::RESP_OKAY;
    // RULE2 status readable; RULE7 high reserved reads zero
    unique case (s_axi_araddr_i)
      pin_irq_pkg::OFF_ENABLE_LOW: rd_v.data = enable_r.low;
      pin_irq_pkg::OFF_STATUS_LOW: rd_v.data = status_r.low;
      pin_irq_pkg::OFF_ENABLE_HIGH: rd_v.data = enable_r.high & HMASK;
      pin_irq_pkg::OFF_STATUS_HIGH: rd_v.data = status_r.high & HMASK;
      pin_irq_pkg::OFF_CLEAR_LOW, pin_irq_pkg::OFF_FORCE_LOW,
      pin_irq_pkg::OFF_CLEAR_HIGH, pin_irq_pkg::OFF_FORCE_HIGH: rd_v.data = 32'h0000_0000;
      default:
      begin
        rd_v.data = 32'h0000_0000;
        rd_v.resp = pin_irq_pkg::RESP_SLVERR;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= pin_irq_pkg::REG_RESET;
      s_axi_rresp_o <= pin_irq_pkg::RESP_OKAY;
    end
    else if (clk_en_i)
    begin
      s_axi_arready_o <= !s_axi_rvalid_o && !(s_axi_arvalid_i && s_axi_arready_o);
      if (s_axi_arvalid_i && s_axi_arready_o)
      begin
        s_axi_rvalid_o <= 1'b1;
        s_axi_rdata_o <= rd_v.data;
        s_axi_rresp_o <= rd_v.resp;
      end
      else if (s_axi_rready_i)
      begin
        s_axi_rvalid_o <= 1'b0;
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  AST_IRQ_FOLLOWS: assert property (clk_en_i |=> irq_o == (|(status_r.low & enable_r.low) || |(status_r.high & enable_r.high))) // RULE1 RULE9
    else $error("Request does not follow enabled status");
  AST_CLEAR_WORKS: assert property (clk_en_i && wr_go && aw_addr_r == pin_irq_pkg::OFF_CLEAR_LOW && wr_bits[0] && !pin_event_low_i[0] |=> !status_r.low[0]) // RULE3
    else $error("Clear did not drop status");
  AST_FORCE_WORKS: assert property (clk_en_i && wr_go && aw_addr_r == pin_irq_pkg::OFF_FORCE_HIGH && wr_bits[17] |=> status_r.high[17]) // RULE4 RULE6
    else $error("Force did not raise status");
  AST_SET_WINS: assert property (clk_en_i && pin_event_low_i[31] |=> status_r.low[31]) // RULE10 RULE5
    else $error("Event lost");
  AST_RSVD_ZERO: assert property (status_r.high[31:18] == 14'h0000 && enable_r.high[31:18] == 14'h0000) // RULE7
    else $error("Reserved bits set");
  AST_STATUS_HOLDS: assert property (clk_en_i && !wr_go && pin_event_low_i == 32'h0000_0000 |=> $stable(status_r.low)) // RULE2
    else $error("Status changed without cause");
  AST_RESET_ZERO: assert property ($rose(rst_b_i) |-> enable_r == '0 && status_r == '0) // RULE8
    else $error("Not zero after reset");
  AST_R_ANSWER: assert property (clk_en_i && s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("No read answer");

  COV_FORCE: cover property (wr_go && aw_addr_r == pin_irq_pkg::OFF_FORCE_LOW ##1 irq_o);
  COV_CLEAR: cover property (irq_o ##[1:20] !irq_o);
  COV_READ: cover property (s_axi_rvalid_o && s_axi_rready_i);

endmodule

// ==== verilog/pin_irq_pkg.sv ====
// Purpose: Shared constants and types for the pin interrupt bank
// Assumes: AXI4-Lite with 32-bit data, word aligned registers
// Notes: Offsets are byte addresses
package pin_irq_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [11:0] OFF_ENABLE_LOW = 12'h0200;
  localparam logic [11:0] OFF_STATUS_LOW = 12'h0204;
  localparam logic [11:0] OFF_CLEAR_LOW = 12'h0208;
  localparam logic [11:0] OFF_FORCE_LOW = 12'h020C;
  localparam logic [11:0] OFF_ENABLE_HIGH = 12'h0210;
  localparam logic [11:0] OFF_STATUS_HIGH = 12'h0214;
  localparam logic [11:0] OFF_CLEAR_HIGH = 12'h0218;
  localparam logic [11:0] OFF_FORCE_HIGH = 12'h021C;

  localparam int ADDR_W = 12;
  localparam int LOW_PINS = 32;
  localparam int HIGH_PINS = 18;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam logic [31:0] HIGH_MASK = 32'h0003_FFFF;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [31:0] low;
    logic [31:0] high;
  } bank_pair_t;

  typedef struct packed {
    logic [31:0] data;
    logic [1:0] resp;
  } read_answer_t;

endpackage
